//--- ifgc_pkg.sv
package ifgc_pkg;

    // System clock and derived timing
    localparam int CLK_HZ     = 100_000_000;
    localparam int TICK_HZ    = 1_000;        // Gate time base, 1 kHz
    localparam int REF_MID_HZ = 100_000;      // Reference rate 100 kHz
    localparam int REF_HI_HZ  = 900_000;      // Reference rate 900 kHz
    localparam int TICK_DIV   = CLK_HZ / TICK_HZ;
    localparam int REF_MID_DIV = CLK_HZ / REF_MID_HZ;
    localparam int REF_HI_DIV  = CLK_HZ / REF_HI_HZ;  // Rounded down
    localparam int TICK_CNT_W = 17;
    localparam int REF_CNT_W  = 10;

    // Gate lengths in 1 ms ticks
    localparam logic [3:0] GATE_1MS = 4'h1;
    localparam logic [3:0] GATE_4MS = 4'h4;
    localparam logic [3:0] GATE_8MS = 4'h8;
    localparam logic [3:0] MS_ZERO  = 4'h0;
    localparam logic [3:0] MS_ONE   = 4'h1;

    // Count register
    localparam int          COUNT_W    = 16;
    localparam logic [6:0]  COUNT_ADDR = 7'h43;
    localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_ONE  = 16'h0001;

    // Gate time select codes
    typedef enum logic [1:0] {
        IFGC_GT_1MS  = 2'b00,
        IFGC_GT_4MS  = 2'b01,
        IFGC_GT_8MS  = 2'b10,
        IFGC_GT_OPEN = 2'b11
    } ifgc_gate_t;

    // Input pin select codes
    typedef enum logic [1:0] {
        IFGC_PIN_EXT  = 2'b00,
        IFGC_PIN_AM   = 2'b01,
        IFGC_PIN_FM   = 2'b10,
        IFGC_PIN_NONE = 2'b11
    } ifgc_pin_t;

    // External gate pin select codes
    localparam logic [1:0] EXT_SEL_A = 2'b01;
    localparam logic [1:0] EXT_SEL_B = 2'b10;

    typedef enum logic [2:0] {
        IFGC_IDLE     = 3'b000,
        IFGC_WAIT_TCK = 3'b001,
        IFGC_TIMED    = 3'b010,
        IFGC_OPEN     = 3'b011,
        IFGC_EXT_WAIT = 3'b100,
        IFGC_EXT_OPEN = 3'b101
    } ifgc_state_t;

    // Pin inputs: fm, am, gate a, gate b
    typedef struct packed {
        logic fm;
        logic am;
        logic gateA;
        logic gateB;
    } ifgc_pins_t;

    // Software control fields
    typedef struct packed {
        ifgc_gate_t gateTime;
        ifgc_pin_t  pinSel;
        logic [1:0] extSel;
    } ifgc_ctrl_t;

    typedef struct packed {
        ifgc_state_t            st;
        ifgc_pins_t             syncA;
        ifgc_pins_t             syncB;
        ifgc_pins_t             prev;
        logic                   fmHalf;
        logic [TICK_CNT_W-1:0]  tickCnt;
        logic [REF_CNT_W-1:0]   refCnt;
        logic [3:0]             msCnt;
        logic [COUNT_W-1:0]     count;
        logic [COUNT_W-1:0]     transferBuffer;
        logic                   gateOpenFlag;
        logic                   gateStatusFlag;
    } ifgc_regs_t;

endpackage

//--- if_frequency_gate_counter.sv
// Functional notes
// - Timed gate opens on first 1 kHz tick after start, stays open selected time.
// - Open timed gate counts the selected pin in a 16-bit counter.
// - In IF mode the gate-open flag clears when the timed gate closes.
// - Gate status flag goes to one as soon as start is set.
// - Open-gate setting opens the gate at once without a start.
// - Counter clear still works while the open-gate setting is active.
// - Leaving the open-gate setting closes the gate.
// - Deselecting the pin in open-gate setting keeps gate open, stops counting.
// - External mode gate spans one gate-pin rising edge to the next.
// - External mode counts the selected 1, 100 or 900 kHz reference.
// - External mode status stays one until the closing gate edge.
// - Writing one to the clear flag zeroes the count.
// - Count saturates at all ones and holds until cleared.
// - FM input is halved before counting; AM input counts directly.
// - Count is read only by transfer into the data buffer at 43H.
// - IF counting increments on rising input edges.
`timescale 1ns/1ps
module if_frequency_gate_counter
    import ifgc_pkg::*;
#(
    parameter int TICK_DIV_P = TICK_DIV
)
(
    input  wire logic                ref_clk,
    input  wire logic                arst_n,
    input  wire ifgc_ctrl_t          ctrl,
    input  wire logic                countStartFlag,
    input  wire logic                countClearFlag,
    input  wire ifgc_pins_t          pins,
    input  wire logic                getStrobe,
    input  wire logic [6:0]          periphAddr,
    output logic [COUNT_W-1:0]       transferBuffer,
    output logic                     gateOpenFlag,
    output logic                     gateStatusFlag
);

    // Gate length for a timed setting; open maps to the longest
    function automatic logic [3:0] gateTarget(input ifgc_gate_t g);
        case (g)
            IFGC_GT_1MS: gateTarget = GATE_1MS;
            IFGC_GT_4MS: gateTarget = GATE_4MS;
            default:     gateTarget = GATE_8MS;
        endcase
    endfunction

    // True when the pin field selects the external gate counter
    function automatic logic isExt(input ifgc_pin_t p);
        isExt = (p == IFGC_PIN_EXT);
    endfunction

    logic       rstPipe1;
    logic       rstPipe2;
    logic       rst_n;
    ifgc_regs_t s;
    ifgc_regs_t next_s;
    ifgc_pins_t edges;
    logic       tickPulse;
    logic       refPulse;
    logic       refWrap;
    logic       gateEdge;
    logic       ifEdge;
    logic       countEv;
    logic [3:0] target;
    logic [REF_CNT_W-1:0] refLast;

    // Reset released through two flops; assertion is asynchronous
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstPipe1 <= 1'b0;
            rstPipe2 <= 1'b0;
        end
        else
        begin
            rstPipe1 <= 1'b1;
            rstPipe2 <= rstPipe1;
        end
    end
    assign rst_n = rstPipe2;

    always_comb
    begin
        next_s = s;
        // Two-stage sync; stage one feeds only stage two
        next_s.syncA = pins;
        next_s.syncB = s.syncA;
        next_s.prev  = s.syncB;
        edges = s.syncB & ~s.prev;

        // Free-running 1 kHz time base
        tickPulse = (s.tickCnt == TICK_CNT_W'(TICK_DIV_P - 1));
        next_s.tickCnt = tickPulse ? '0 : s.tickCnt + 1'b1;

        // Reference divider; 900 kHz is truncated to a whole period
        refLast = (ctrl.gateTime == IFGC_GT_8MS)
                ? REF_CNT_W'(REF_HI_DIV - 1)
                : REF_CNT_W'(REF_MID_DIV - 1);
        refWrap = (s.refCnt >= refLast);
        next_s.refCnt = refWrap ? '0 : s.refCnt + 1'b1;
        refPulse = (ctrl.gateTime == IFGC_GT_1MS) ? tickPulse : refWrap;

        // FM edges pass a divide-by-two stage
        if (edges.fm)
            next_s.fmHalf = ~s.fmHalf;
        case (ctrl.pinSel)
            IFGC_PIN_FM: ifEdge = edges.fm & s.fmHalf;
            IFGC_PIN_AM: ifEdge = edges.am;
            default:     ifEdge = 1'b0;
        endcase

        case (ctrl.extSel)
            EXT_SEL_A: gateEdge = edges.gateA;
            EXT_SEL_B: gateEdge = edges.gateB;
            default:   gateEdge = 1'b0;
        endcase

        target = gateTarget(ctrl.gateTime);

        // Gate sequencing; a start restarts from any state
        if (countStartFlag)
        begin
            next_s.gateStatusFlag = 1'b1;
            next_s.gateOpenFlag   = 1'b0;
            next_s.msCnt          = MS_ZERO;
            next_s.st = isExt(ctrl.pinSel) ? IFGC_EXT_WAIT : IFGC_WAIT_TCK;
        end
        else
        begin
            case (s.st)
                IFGC_IDLE:
                begin
                    if (ctrl.gateTime == IFGC_GT_OPEN && !isExt(ctrl.pinSel))
                    begin
                        next_s.st = IFGC_OPEN;
                        next_s.gateOpenFlag = 1'b1;
                    end
                end
                IFGC_WAIT_TCK:
                begin
                    if (tickPulse)
                    begin
                        next_s.st = IFGC_TIMED;
                        next_s.gateOpenFlag = 1'b1;
                    end
                end
                IFGC_TIMED:
                begin
                    // Started in open setting: closes after 8 ms here
                    if (tickPulse)
                    begin
                        if (s.msCnt + MS_ONE == target)
                        begin
                            next_s.st = IFGC_IDLE;
                            next_s.gateOpenFlag   = 1'b0;
                            next_s.gateStatusFlag = 1'b0;
                        end
                        else
                            next_s.msCnt = s.msCnt + MS_ONE;
                    end
                end
                IFGC_OPEN:
                begin
                    if (ctrl.gateTime != IFGC_GT_OPEN || isExt(ctrl.pinSel))
                    begin
                        next_s.st = IFGC_IDLE;
                        next_s.gateOpenFlag = 1'b0;
                    end
                end
                IFGC_EXT_WAIT:
                begin
                    if (gateEdge)
                        next_s.st = IFGC_EXT_OPEN;
                end
                IFGC_EXT_OPEN:
                begin
                    if (gateEdge)
                    begin
                        next_s.st = IFGC_IDLE;
                        next_s.gateStatusFlag = 1'b0;
                    end
                end
                default:
                begin
                    next_s.st = IFGC_IDLE;
                    next_s.gateOpenFlag   = 1'b0;
                    next_s.gateStatusFlag = 1'b0;
                end
            endcase
        end

        // Count events while the gate is open
        case (s.st)
            IFGC_TIMED,
            IFGC_OPEN:     countEv = ifEdge;
            IFGC_EXT_OPEN: countEv = refPulse;
            default:       countEv = 1'b0;
        endcase

        // Clear beats a coincident count so a cleared result reads zero
        if (countClearFlag)
            next_s.count = COUNT_ZERO;
        else if (countEv && s.count != COUNT_MAX)
            next_s.count = s.count + COUNT_ONE;

        // Only path to the count: transfer into the buffer
        if (getStrobe && periphAddr == COUNT_ADDR)
            next_s.transferBuffer = s.count;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs straight from state flops
    assign transferBuffer = s.transferBuffer;
    assign gateOpenFlag   = s.gateOpenFlag;
    assign gateStatusFlag = s.gateStatusFlag;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence gateClosed;
        !gateOpenFlag && !gateStatusFlag && s.st == IFGC_IDLE;
    endsequence

    sequence timedLastTick;
        s.st == IFGC_TIMED && tickPulse && !countStartFlag
            && s.msCnt + MS_ONE == target;
    endsequence

    status_on_start_a: assert property (
        countStartFlag |=> gateStatusFlag && !gateOpenFlag)
        else $error("status flag not set by start");

    timed_close_a: assert property (
        timedLastTick |=> gateClosed)
        else $error("timed gate did not close");

    tick_open_a: assert property (
        s.st == IFGC_WAIT_TCK && tickPulse && !countStartFlag
            |=> s.st == IFGC_TIMED && gateOpenFlag && s.msCnt == MS_ZERO)
        else $error("gate not opened on tick");

    open_select_a: assert property (
        s.st == IFGC_IDLE && ctrl.gateTime == IFGC_GT_OPEN
            && !isExt(ctrl.pinSel) && !countStartFlag
            |=> gateOpenFlag && s.st == IFGC_OPEN)
        else $error("open setting did not open gate");

    open_leave_a: assert property (
        s.st == IFGC_OPEN && ctrl.gateTime != IFGC_GT_OPEN
            && !countStartFlag |=> !gateOpenFlag && s.st == IFGC_IDLE)
        else $error("gate stayed open after deselect");

    pin_off_a: assert property (
        s.st == IFGC_OPEN && ctrl.pinSel == IFGC_PIN_NONE
            && !countClearFlag && ctrl.gateTime == IFGC_GT_OPEN
            |=> $stable(s.count) && gateOpenFlag)
        else $error("count moved with pin deselected");

    count_clear_a: assert property (
        countClearFlag |=> s.count == COUNT_ZERO)
        else $error("count not cleared");

    count_sat_a: assert property (
        s.count == COUNT_MAX && !countClearFlag |=> s.count == COUNT_MAX)
        else $error("count wrapped past maximum");

    count_step_a: assert property (
        !countClearFlag && countEv && s.count != COUNT_MAX
            |=> s.count == $past(s.count) + COUNT_ONE)
        else $error("count did not step on event");

    ext_open_a: assert property (
        s.st == IFGC_EXT_WAIT && gateEdge && !countStartFlag
            |=> s.st == IFGC_EXT_OPEN && gateStatusFlag)
        else $error("external gate did not open");

    ext_close_a: assert property (
        s.st == IFGC_EXT_OPEN && gateEdge && !countStartFlag
            |=> gateClosed)
        else $error("external gate did not close");

    fm_half_a: assert property (
        edges.fm |=> s.fmHalf != $past(s.fmHalf))
        else $error("fm divider did not toggle");

    transfer_a: assert property (
        getStrobe && periphAddr == COUNT_ADDR
            |=> transferBuffer == $past(s.count))
        else $error("transfer buffer missed count");

endmodule

//--- ifgc_source.sv
`timescale 1ns/1ps
module ifgc_source
    import ifgc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        ifRun,
    input  wire logic        gateRun,
    input  wire logic [15:0] ifHalf,
    input  wire logic [15:0] gateHalf,
    output ifgc_pins_t       pins
);
    logic [15:0] ifCnt;
    logic [15:0] gtCnt;
    logic        ifOn;
    logic        gtOn;

    // Sources start low and rest low when stopped
    initial
    begin
        pins = '0;
        ifCnt = 16'h0000;
        gtCnt = 16'h0000;
    end

    // Run controls taken at the edge, so a bench change 1 ns later
    // cannot race the pin update that follows
    always @(posedge ref_clk)
    begin
        ifOn = ifRun;
        gtOn = gateRun;
        #1;
        ifCnt = ifOn ? ifCnt + 16'h0001 : 16'h0000;
        gtCnt = gtOn ? gtCnt + 16'h0001 : 16'h0000;
        if (!ifOn)
            {pins.fm, pins.am} = 2'b00;
        if (!gtOn)
            {pins.gateA, pins.gateB} = 2'b00;
        if (ifCnt == ifHalf)
        begin
            ifCnt = 16'h0000;
            pins.fm = ~pins.fm;
            pins.am = ~pins.am;
        end
        if (gtCnt == gateHalf)
        begin
            gtCnt = 16'h0000;
            pins.gateA = ~pins.gateA;
            pins.gateB = ~pins.gateB;
        end
    end
endmodule

//--- if_frequency_gate_counter_bench.sv
`timescale 1ns/1ps
module if_frequency_gate_counter_bench
    import ifgc_pkg::*;
;
    localparam int TD = 50;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    ifgc_ctrl_t  ctrl = '{IFGC_GT_1MS, IFGC_PIN_AM, EXT_SEL_A};
    logic        countStartFlag = 1'b0;
    logic        countClearFlag = 1'b0;
    ifgc_pins_t  pins;
    logic        getStrobe = 1'b0;
    logic [6:0]  periphAddr = 7'h00;
    logic [15:0] transferBuffer;
    logic        gateOpenFlag;
    logic        gateStatusFlag;
    logic        ifRun = 1'b0;
    logic        gateRun = 1'b0;
    int          fails = 0;
    int          n_compared = 0;
    int          k;
    logic [15:0] v;
    ifgc_gate_t  gts[4] = '{IFGC_GT_1MS, IFGC_GT_4MS, IFGC_GT_8MS,
                            IFGC_GT_1MS};
    ifgc_pin_t   psel[4] = '{IFGC_PIN_AM, IFGC_PIN_AM, IFGC_PIN_AM,
                             IFGC_PIN_FM};
    int          ms[4] = '{1, 4, 8, 1};
    logic [15:0] lo[4] = '{16'h0005, 16'h0014, 16'h0028, 16'h0002};
    logic [15:0] elo[3] = '{16'h002C, 16'h0002, 16'h0014};

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    if_frequency_gate_counter #(.TICK_DIV_P(TD)) dut (
        .ref_clk        (ref_clk),
        .arst_n         (arst_n),
        .ctrl           (ctrl),
        .countStartFlag (countStartFlag),
        .countClearFlag (countClearFlag),
        .pins           (pins),
        .getStrobe      (getStrobe),
        .periphAddr     (periphAddr),
        .transferBuffer (transferBuffer),
        .gateOpenFlag   (gateOpenFlag),
        .gateStatusFlag (gateStatusFlag)
    );

    // IF source toggles every 5 cycles, gate every 1110
    ifgc_source src (
        .ref_clk  (ref_clk),
        .ifRun    (ifRun),
        .gateRun  (gateRun),
        .ifHalf   (16'h0005),
        .gateHalf (16'h0456),
        .pins     (pins)
    );

    function automatic logic [15:0] flag(input logic b);
        return {15'h0000, b};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen,
                     exp);
        end
    endtask

    // Edge phase gives a one-count spread, so accept a window
    task automatic rng(input logic [15:0] s, input logic [15:0] l);
        check(s, ((s >= l) && (s <= l + 16'h0001)) === 1'b1 ? s : l);
    endtask

    task automatic tick(input int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic clr();
        countClearFlag = 1'b1;
        tick();
        countClearFlag = 1'b0;
    endtask

    task automatic start();
        countStartFlag = 1'b1;
        tick();
        countStartFlag = 1'b0;
    endtask

    task automatic xfer(input logic [6:0] a);
        periphAddr = a;
        getStrobe = 1'b1;
        tick();
        getStrobe = 1'b0;
        tick();
    endtask

    task automatic wait_close(input int lim);
        k = 0;
        while (gateStatusFlag !== 1'b0 && k < lim)
        begin
            tick();
            k++;
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        tick(3);
        arst_n = 1'b1;
        tick(3);
        check(transferBuffer, COUNT_ZERO);
        check(flag(gateStatusFlag), COUNT_ZERO);
        $display("reset test done");
        ifRun = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            ctrl.gateTime = gts[i];
            ctrl.pinSel = psel[i];
            clr();
            start();
            check(flag(gateStatusFlag), COUNT_ONE);
            k = 0;
            while (gateOpenFlag !== 1'b1 && k < TD + 4)
            begin
                tick();
                k++;
            end
            check(flag(k <= TD + 2), COUNT_ONE);
            k = 0;
            while (gateOpenFlag === 1'b1 && k < 1000)
            begin
                tick();
                k++;
            end
            check(16'(k), 16'(ms[i] * TD));
            wait_close(4);
            check(flag(gateStatusFlag), COUNT_ZERO);
            xfer(COUNT_ADDR);
            rng(transferBuffer, lo[i]);
            $display("timed gate test %0d done", i);
        end
        // Open gate: no start may be issued here
        ctrl.gateTime = IFGC_GT_OPEN;
        ctrl.pinSel = IFGC_PIN_AM;
        tick(3);
        check(flag(gateOpenFlag), COUNT_ONE);
        clr();
        tick(100);
        ctrl.pinSel = IFGC_PIN_NONE;
        tick(4);
        xfer(COUNT_ADDR);
        v = transferBuffer;
        check(flag(v >= 16'h0009 && v <= 16'h000C), COUNT_ONE);
        tick(100);
        xfer(COUNT_ADDR);
        check(transferBuffer, v);
        check(flag(gateOpenFlag), COUNT_ONE);
        clr();
        xfer(7'h42);
        check(transferBuffer, v);
        xfer(COUNT_ADDR);
        check(transferBuffer, COUNT_ZERO);
        ctrl.gateTime = IFGC_GT_1MS;
        tick(2);
        check(flag(gateOpenFlag), COUNT_ZERO);
        $display("open gate test done");
        // External gate over each reference rate and both pins
        ctrl.pinSel = IFGC_PIN_EXT;
        ifRun = 1'b0;
        gateRun = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            ctrl.gateTime = ifgc_gate_t'(2'(i));
            ctrl.extSel = (i == 1) ? EXT_SEL_B : EXT_SEL_A;
            clr();
            start();
            check(flag(gateStatusFlag), COUNT_ONE);
            wait_close(6000);
            check(flag(gateStatusFlag), COUNT_ZERO);
            check(flag(k >= 2220), COUNT_ONE);
            check(flag(gateOpenFlag), COUNT_ZERO);
            xfer(COUNT_ADDR);
            rng(transferBuffer, elo[i]);
            $display("external gate test %0d done", i);
        end
        wrap_up();
    end

    // Watchdog, well beyond the expected run length
    initial
    begin
        #400000;
        fails++;
        wrap_up();
    end
endmodule
